// ===== rtl/touchpad_cfg.svh
// Constants of the touchpad packet slave: address, packet codes,
// default values and lengths. Included by the design files only.
`ifndef TOUCHPAD_CFG_SVH
`define TOUCHPAD_CFG_SVH

`define TP_SLAVE_ADDR   7'h10
`define TP_ID_HELLO     8'h55
`define TP_ID_RESP      8'h52
`define TP_ID_READ      8'h53
`define TP_ID_WRITE     8'h54
`define TP_ID_REPORT    8'h5A
`define TP_TAIL         8'h01
`define TP_FILL         8'hFF
`define TP_SEL_FWVER    8'h00
`define TP_SEL_POWER    8'h50
`define TP_SEL_FWID     8'hF0
`define TP_NIB_SENS     4'h4
`define TP_NIB_POWER    4'h5
`define TP_FWVER_B3     8'h00
`define TP_FWVER_B4     8'h11
`define TP_FWID_B2      8'hA5 // Arbitrary identity value
`define TP_FWID_B3      8'h3C // Arbitrary identity value
`define TP_FWID_B4      8'h81 // Arbitrary identity value
`define TP_PWR_RST      2'h2
`define TP_RATE_RST     4'hA
`define TP_SENSX_RST    4'h5
`define TP_SENSY_RST    4'h4
`define TP_LEN_SHORT    4'h4
`define TP_LEN_REPORT   4'h8
`define TP_CMD_LEN      3'h4
`define TP_BITS         4'h8

`endif

// ===== rtl/touchpad_i2c_packet_slave.sv
// Touchpad host link: serial slave exchanging command and touch packets.
// Assumes the host masters the bus and meets fast-mode timing.
// How it works
// [RQ1] Acts only as slave; SCL is never driven, only SDA.
// [RQ2] The host makes every SCL pulse of every transfer.
// [RQ3] Link runs up to 400 kbit/s; host never clocks faster.
// [RQ4] Answers address 0x20 documented, seven bits 0010000.
// [RQ5] First byte LSB picks direction: one read, zero write.
// [RQ6] Hello packet is four bytes of 0x55.
// [RQ7] Hello is the first packet delivered after initialisation.
// [RQ8] Host read packet: 0x53, selector, data, 0x01.
// [RQ9] Host write packet: 0x54, register and value, data, 0x01.
// [RQ10] Every accepted read gets a four-byte 0x52 response; a read while a response is still unloaded replaces it.
// [RQ11] Selector 0x00 version, 0x50 power, 0xF0 firmware identifier.
// [RQ12] Default power read returns 0x58 0x0A 0x01.
// [RQ13] Write with second byte 0x45 sets sensitivity five.
// [RQ14] Sensitivity response byte two: x level high, y level low.
// [RQ15] Position reports are eight bytes starting 0x5A.
// [RQ16] Coordinates 12 bits: high nibbles byte, then X low, Y low.
// [RQ17] Last byte: zeros, finger count in bits 2..1, one in bit 0.
// [RQ18] Finger lift sends 0x5A, six zero bytes, 0x01.
// [RQ19] Touch-down and every move send an absolute report; a move before the report is loaded replaces the unsent one.
// [RQ20] Before the release report the last position is resent.
// [RQ21] Attention goes low while a packet waits for the host.
// [RQ22] Attention returns high once the host read the packet.
// [RQ23] Host fetches the packet by a read of its length.
// [RQ24] Packets with unknown identifiers are ignored, no response.
`timescale 1ns/1ps
`include "touchpad_cfg.svh"

module touchpad_i2c_packet_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             attn_n,
  input  wire logic        init_done,
  input  wire logic        touch_valid,
  input  wire logic [1:0]  touch_fingers,
  input  wire logic [11:0] touch_x1,
  input  wire logic [11:0] touch_y1,
  input  wire logic [11:0] touch_x2,
  input  wire logic [11:0] touch_y2,
  output logic      [3:0]  sens_x,
  output logic      [3:0]  sens_y,
  output logic      [1:0]  power_state,
  output logic      [3:0]  report_rate
);

  touchpad_pkg::link_state_e state_reg, state_next;
  touchpad_pkg::byte_t       sh_reg, sh_next, tx_byte;
  touchpad_pkg::byte_t       pkt_reg [0:7];
  touchpad_pkg::byte_t       rx_reg  [0:3];
  logic [3:0]  bit_reg, bit_next, len_reg, tx_cnt_reg;
  logic [2:0]  rx_cnt_reg;
  logic        drive_reg, drive_next, rd_xfer_reg, wr_xfer_reg;
  logic        scl_f, sda_f, scl_q, sda_q;
  logic        pend_reg, hello_done_reg, resp_pend_reg;
  logic        rep_pend_reg, rel_pend_reg, touch_pend_reg, touched_reg;
  logic [7:0]  resp_sel_reg;
  logic [1:0]  cur_fing_reg;
  logic [11:0] cur_x1_reg, cur_y1_reg, cur_x2_reg, cur_y2_reg;
  logic [63:0] report_flat;
  logic [31:0] resp_flat;
  logic        rel_sel;

  // Pins come from the host's domain: three stages and agreement, see [RQ3]
  tp_pin_sync u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({scl_in, sda_in}),
    .pin_level ({scl_f, sda_f})
  );

  // Bus events from the filtered levels
  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;
  wire end_xfer  = start_det | stop_det;
  wire byte_in   = (bit_reg == `TP_BITS);
  wire addr_hit  = (sh_reg[7:1] == `TP_SLAVE_ADDR); // see [RQ4]
  wire rw_read   = sh_reg[0];                        // see [RQ5]
  wire tack_nack = (state_reg == touchpad_pkg::ST_TACK) & scl_rise & sda_f;

  // Byte sent next; released bus reads as fill past the packet
  assign tx_byte = (pend_reg && tx_cnt_reg < len_reg) ?
                   pkt_reg[tx_cnt_reg[2:0]] : `TP_FILL;

  // Serial engine; data changes only after SCL falls, so hold is met
  always_comb begin
    state_next = state_reg;
    sh_next    = sh_reg;
    bit_next   = bit_reg;
    drive_next = drive_reg;
    if (stop_det) begin
      state_next = touchpad_pkg::ST_IDLE;
      drive_next = 1'b0;
    end else if (start_det) begin
      state_next = touchpad_pkg::ST_ADDR;
      bit_next   = 4'h0;
      drive_next = 1'b0;
    end else begin
      unique case (state_reg)
        touchpad_pkg::ST_IDLE: ;
        touchpad_pkg::ST_ADDR, touchpad_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_f};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && byte_in) begin
            if (state_reg == touchpad_pkg::ST_RX) begin
              state_next = touchpad_pkg::ST_RACK;
              drive_next = 1'b1;
            end else if (addr_hit) begin
              state_next = touchpad_pkg::ST_AACK;
              drive_next = 1'b1;
            end else begin
              state_next = touchpad_pkg::ST_IDLE;
            end
          end
        end
        touchpad_pkg::ST_AACK: begin
          if (scl_fall && rw_read) begin
            state_next = touchpad_pkg::ST_TX;
            sh_next    = tx_byte;
            drive_next = ~tx_byte[7];
            bit_next   = 4'h1;
          end else if (scl_fall) begin
            state_next = touchpad_pkg::ST_RX;
            drive_next = 1'b0;
            bit_next   = 4'h0;
          end
        end
        touchpad_pkg::ST_RACK: begin
          if (scl_fall) begin
            state_next = touchpad_pkg::ST_RX;
            drive_next = 1'b0;
            bit_next   = 4'h0;
          end
        end
        touchpad_pkg::ST_TX: begin
          if (scl_fall && byte_in) begin
            state_next = touchpad_pkg::ST_TACK;
            drive_next = 1'b0;
          end else if (scl_fall) begin
            sh_next    = {sh_reg[6:0], 1'b0};
            drive_next = ~sh_reg[6];
            bit_next   = bit_reg + 4'h1;
          end
        end
        touchpad_pkg::ST_TACK: begin
          if (tack_nack) begin
            state_next = touchpad_pkg::ST_IDLE;
          end else if (scl_rise) begin
            bit_next = 4'h0;
          end else if (scl_fall && bit_reg == 4'h0) begin
            state_next = touchpad_pkg::ST_TX;
            sh_next    = tx_byte;
            drive_next = ~tx_byte[7];
            bit_next   = 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= touchpad_pkg::ST_IDLE;
      sh_reg    <= 8'h00;
      bit_reg   <= 4'h0;
      drive_reg <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      state_reg <= state_next;
      sh_reg    <= sh_next;
      bit_reg   <= bit_next;
      drive_reg <= drive_next;
      scl_q     <= scl_f;
      sda_q     <= sda_f;
    end
  end

  // Only a low is ever driven on SDA; SCL has no output at all
  assign sda_out  = 1'b0;       // see [RQ1]
  assign sda_oe_n = ~drive_reg; // see [RQ1]

  // Transaction bookkeeping
  wire aack_end  = (state_reg == touchpad_pkg::ST_AACK) & scl_fall;
  wire rx_store  = (state_reg == touchpad_pkg::ST_RX) & scl_fall & byte_in;
  wire tx_done   = (state_reg == touchpad_pkg::ST_TACK) & scl_rise;
  // Packet counts as read once all its bytes went out, see [RQ23]
  // A refused last byte ends the read before its count has landed
  wire read_done = rd_xfer_reg & pend_reg &
                   ((end_xfer & (tx_cnt_reg >= len_reg)) |
                    (tack_nack & (tx_cnt_reg >= len_reg - 4'h1)));
  wire cmd_end   = end_xfer & wr_xfer_reg & (rx_cnt_reg == `TP_CMD_LEN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_xfer_reg <= 1'b0;
      wr_xfer_reg <= 1'b0;
      tx_cnt_reg  <= 4'h0;
      rx_cnt_reg  <= 3'h0;
    end else begin
      rd_xfer_reg <= end_xfer | tack_nack ? 1'b0 :
                     aack_end ? rw_read : rd_xfer_reg;
      wr_xfer_reg <= end_xfer ? 1'b0 :
                     aack_end ? ~rw_read : wr_xfer_reg;
      tx_cnt_reg  <= start_det ? 4'h0 :
                     tx_done && tx_cnt_reg != 4'hF ? tx_cnt_reg + 4'h1 :
                     tx_cnt_reg;
      // Overlong writes count past four and are then dropped
      rx_cnt_reg  <= start_det ? 3'h0 :
                     rx_store && rx_cnt_reg != 3'h7 ? rx_cnt_reg + 3'h1 :
                     rx_cnt_reg;
    end
  end

  // Received command bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) rx_reg[i] <= 8'h00;
    end else if (rx_store && rx_cnt_reg < `TP_CMD_LEN) begin
      rx_reg[rx_cnt_reg[1:0]] <= sh_reg;
    end
  end

  // Command decode, see [RQ8] [RQ9]
  wire is_read  = cmd_end & (rx_reg[0] == `TP_ID_READ);
  wire is_write = cmd_end & (rx_reg[0] == `TP_ID_WRITE);
  wire sel_ok   = (rx_reg[1] == `TP_SEL_FWVER) |
                  (rx_reg[1] == `TP_SEL_POWER) |
                  (rx_reg[1] == `TP_SEL_FWID)  |
                  (rx_reg[1][7:4] == `TP_NIB_SENS); // see [RQ11]
  wire wr_sens  = is_write & (rx_reg[1][7:4] == `TP_NIB_SENS);
  wire wr_power = is_write & (rx_reg[1][7:4] == `TP_NIB_POWER);

  // Settings steered by host writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sens_x      <= `TP_SENSX_RST;
      sens_y      <= `TP_SENSY_RST;
      power_state <= `TP_PWR_RST;
      report_rate <= `TP_RATE_RST;
    end else begin
      if (wr_sens) begin
        sens_x <= rx_reg[1][3:0]; // see [RQ13]
        sens_y <= rx_reg[1][3:0]; // see [RQ13]
      end
      if (wr_power) begin
        power_state <= rx_reg[1][3:2];
        report_rate <= rx_reg[2][3:0];
      end
    end
  end

  // Response bytes by selector, see [RQ10] [RQ11] [RQ12] [RQ14]
  wire [31:0] resp_ver  = {`TP_ID_RESP, `TP_SEL_FWVER,
                           `TP_FWVER_B3, `TP_FWVER_B4};
  wire [31:0] resp_pwr  = {`TP_ID_RESP, `TP_NIB_POWER, power_state, 2'h0,
                           4'h0, report_rate, `TP_TAIL};
  wire [31:0] resp_id   = {`TP_ID_RESP, `TP_FWID_B2,
                           `TP_FWID_B3, `TP_FWID_B4};
  wire [31:0] resp_sens = {`TP_ID_RESP, sens_x, sens_y, 8'h00, `TP_TAIL};
  assign resp_flat = (resp_sel_reg == `TP_SEL_FWVER) ? resp_ver :
                     (resp_sel_reg == `TP_SEL_POWER) ? resp_pwr :
                     (resp_sel_reg == `TP_SEL_FWID)  ? resp_id  : resp_sens;

  // Release report is the formatter fed with zeros, see [RQ18]
  tp_report_fmt u_fmt (
    .fingers (rel_sel ? 2'h0  : cur_fing_reg),
    .x1      (rel_sel ? 12'h0 : cur_x1_reg),
    .y1      (rel_sel ? 12'h0 : cur_y1_reg),
    .x2      (rel_sel ? 12'h0 : cur_x2_reg),
    .y2      (rel_sel ? 12'h0 : cur_y2_reg),
    .report  (report_flat)
  );

  // Slot arbitration: hello gates all, then responses, then touch
  wire slot_free  = ~pend_reg | read_done;
  wire load_hello = slot_free & ~hello_done_reg & init_done; // see [RQ7]
  wire load_resp  = slot_free & hello_done_reg & resp_pend_reg;
  wire load_rep   = slot_free & hello_done_reg & ~resp_pend_reg &
                    rep_pend_reg;                            // see [RQ20]
  wire load_rel   = slot_free & hello_done_reg & ~resp_pend_reg &
                    ~rep_pend_reg & rel_pend_reg;
  wire load_touch = slot_free & hello_done_reg & ~resp_pend_reg &
                    ~rep_pend_reg & ~rel_pend_reg & touch_pend_reg;
  assign rel_sel  = load_rel;
  wire load_rpt   = load_rep | load_rel | load_touch;
  wire load_any   = load_hello | load_resp | load_rpt;
  wire lift       = touch_valid & (touch_fingers == 2'h0);
  wire move       = touch_valid & (touch_fingers != 2'h0);

  // Packet slot; a load in the cycle of read completion wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) pkt_reg[i] <= 8'h00;
      len_reg <= 4'h0;
    end else if (load_hello) begin
      for (int i = 0; i < 4; i++) pkt_reg[i] <= `TP_ID_HELLO; // see [RQ6]
      len_reg <= `TP_LEN_SHORT;
    end else if (load_resp) begin
      for (int i = 0; i < 4; i++) pkt_reg[i] <= resp_flat[31-8*i -: 8];
      len_reg <= `TP_LEN_SHORT;
    end else if (load_rpt) begin
      for (int i = 0; i < 8; i++) pkt_reg[i] <= report_flat[63-8*i -: 8];
      len_reg <= `TP_LEN_REPORT;
    end
  end

  // Pending flags; hardware set beats the read-done clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg       <= 1'b0;
      hello_done_reg <= 1'b0;
      resp_pend_reg  <= 1'b0;
      resp_sel_reg   <= 8'h00;
    end else begin
      pend_reg       <= load_any | (pend_reg & ~read_done); // see [RQ22]
      hello_done_reg <= hello_done_reg | load_hello;
      // Unknown ids and selectors leave no response, see [RQ24]
      resp_pend_reg  <= (is_read & sel_ok) | (resp_pend_reg & ~load_resp);
      if (is_read && sel_ok) resp_sel_reg <= rx_reg[1];
    end
  end

  // Touch tracking: newest coordinates replace unsent ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touched_reg    <= 1'b0;
      touch_pend_reg <= 1'b0;
      rep_pend_reg   <= 1'b0;
      rel_pend_reg   <= 1'b0;
      cur_fing_reg   <= 2'h0;
      cur_x1_reg     <= 12'h000;
      cur_y1_reg     <= 12'h000;
      cur_x2_reg     <= 12'h000;
      cur_y2_reg     <= 12'h000;
    end else begin
      touched_reg    <= move | (touched_reg & ~lift);
      touch_pend_reg <= move | (touch_pend_reg & ~load_touch & ~lift);
      rep_pend_reg   <= (lift & touched_reg) | (rep_pend_reg & ~load_rep);
      rel_pend_reg   <= (lift & touched_reg) | (rel_pend_reg & ~load_rel);
      if (move) begin // see [RQ19]
        cur_fing_reg <= touch_fingers;
        cur_x1_reg   <= touch_x1;
        cur_y1_reg   <= touch_y1;
        cur_x2_reg   <= touch_x2;
        cur_y2_reg   <= touch_y2;
      end
    end
  end

  // Attention follows the slot, one cycle behind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) attn_n <= 1'b1;
    else        attn_n <= ~pend_reg; // see [RQ21] [RQ22]
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sda_only_low: assert property ( // see [RQ1]
    state_reg == touchpad_pkg::ST_IDLE |-> sda_oe_n && sda_out == 1'b0)
    else $error("slave drove SDA high or while idle");
  a_addr_ack_match: assert property ( // see [RQ4]
    state_reg == touchpad_pkg::ST_ADDR && state_next == touchpad_pkg::ST_AACK
    |-> sh_reg[7:1] == 7'h10)
    else $error("acknowledged a foreign address");
  a_dir_select: assert property ( // see [RQ5]
    aack_end && !end_xfer |=> (rd_xfer_reg == $past(sh_reg[0])))
    else $error("direction bit misread");
  a_hello_bytes: assert property (load_hello |=> // see [RQ6]
    pkt_reg[0] == 8'h55 && pkt_reg[3] == 8'h55 && len_reg == 4'h4)
    else $error("hello packet malformed");
  a_hello_first: assert property ($rose(pend_reg) && // see [RQ7]
    !$past(hello_done_reg) |-> pkt_reg[1] == 8'h55)
    else $error("packet before hello");
  a_resp_id: assert property (load_resp |=> // see [RQ10]
    pkt_reg[0] == 8'h52 && len_reg == 4'h4)
    else $error("response id wrong");
  a_report_frame: assert property (load_rpt |=> // see [RQ15] [RQ17]
    pkt_reg[0] == 8'h5A && pkt_reg[7][7:3] == 5'h00 && pkt_reg[7][0]
    && len_reg == 4'h8)
    else $error("report frame wrong");
  a_release_zero: assert property (load_rel |=> // see [RQ18]
    pkt_reg[1] == 8'h00 && pkt_reg[6] == 8'h00 && pkt_reg[7] == 8'h01)
    else $error("release report not zero");
  a_attn_follow: assert property (pend_reg |=> !attn_n) // see [RQ21]
    else $error("attention not asserted");
  a_attn_release: assert property ( // see [RQ22]
    read_done && !load_any |=> !pend_reg ##1 attn_n)
    else $error("attention not released");
  a_bad_id_quiet: assert property (cmd_end && // see [RQ24]
    rx_reg[0] != 8'h53 && !resp_pend_reg |=> !resp_pend_reg)
    else $error("response to unknown id");

  c_hello: cover property (read_done && pkt_reg[0] == 8'h55);
  c_resp:  cover property (load_resp);
  c_lift:  cover property (load_rel);
  c_sens:  cover property (wr_sens);

endmodule // touchpad_i2c_packet_slave

// ===== rtl/touchpad_pkg.sv
// Types shared by the touchpad packet slave.
// Constants live in touchpad_cfg.svh.
package touchpad_pkg;

  // Serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_RX   = 7'b0001000,
    ST_RACK = 7'b0010000,
    ST_TX   = 7'b0100000,
    ST_TACK = 7'b1000000
  } link_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ===== rtl/tp_pin_sync.sv
// Three-stage synchroniser with agreement filter for the bus pins.
// Assumes pins idle high; output moves once stages two and three agree.
`timescale 1ns/1ps

module tp_pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_level
);

  logic [1:0] ff1_reg;
  logic [1:0] ff2_reg;
  logic [1:0] ff3_reg;
  logic [1:0] level_reg;
  logic [1:0] level_next;

  // Per-pin filter; stage one feeds only stage two
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      assign level_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i]
                                                        : level_reg[i];
    end
  endgenerate

  // Released bus reads high, so reset to ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg   <= 2'h3;
      ff2_reg   <= 2'h3;
      ff3_reg   <= 2'h3;
      level_reg <= 2'h3;
    end else begin
      ff1_reg   <= pin_in;
      ff2_reg   <= ff1_reg;
      ff3_reg   <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign pin_level = level_reg;

endmodule // tp_pin_sync

// ===== rtl/tp_report_fmt.sv
// Formats an eight-byte position report from finger coordinates.
// Pure logic; the caller registers the result into its packet slot.
`timescale 1ns/1ps
`include "touchpad_cfg.svh"

module tp_report_fmt (
  input  wire logic [1:0]  fingers,
  input  wire logic [11:0] x1,
  input  wire logic [11:0] y1,
  input  wire logic [11:0] x2,
  input  wire logic [11:0] y2,
  output logic      [63:0] report
);

  // Byte 1 in the top lane, byte 8 in the bottom lane
  assign report = {`TP_ID_REPORT,                // see [RQ15]
                   x1[11:8], y1[11:8], x1[7:0], y1[7:0], // see [RQ16]
                   x2[11:8], y2[11:8], x2[7:0], y2[7:0], // see [RQ16]
                   5'h00, fingers, 1'b1};        // see [RQ17]

endmodule // tp_report_fmt

// ===== sim/tb.sv
// Self-checking bench for the touchpad packet slave.
// Host model on the bus; touch samples driven at the falling clock edge.
`timescale 1ns/1ps

module tb;
  logic        clk;
  logic        rst_n;
  logic        init_done;
  logic        touch_valid;
  logic [1:0]  touch_fingers;
  logic [11:0] tx1, ty1, tx2, ty2;
  logic        scl, host_low, sda, sda_oe_n, attn_n;
  logic [3:0]  sens_x, sens_y, report_rate;
  logic [1:0]  power_state;
  int          fail_count = 0;
  int          checks_done = 0;
  logic [31:0] cmd_rows [3] = '{32'h53000001, 32'h53F00001, 32'h53400001};
  logic [31:0] exp_rows [3] = '{32'h52000011, 32'h52A53C81, 32'h52550001};

  // Pull-up wins unless some party pulls the data line low
  assign sda = ~(host_low | ~sda_oe_n);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  touchpad_i2c_packet_slave dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_n(sda_oe_n), .attn_n(attn_n), .init_done(init_done),
    .touch_valid(touch_valid), .touch_fingers(touch_fingers),
    .touch_x1(tx1), .touch_y1(ty1), .touch_x2(tx2), .touch_y2(ty2),
    .sens_x(sens_x), .sens_y(sens_y), .power_state(power_state),
    .report_rate(report_rate)
  );

  tp_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));

  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL %0t ns: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Bounded wait on the attention line; a stuck line ends the run
  task automatic wait_attn(input logic lvl);
    for (int n = 0; n < 4000 && attn_n !== lvl; n++) begin
      @(negedge clk);
    end
    if (attn_n !== lvl) begin
      $display("FAIL %0t ns: attention line stuck", $time);
      fail_count++;
      test_done();
    end
  endtask

  // Fetch a pending packet by a read of its length
  task automatic fetch(input int n, input logic [63:0] exp);
    logic [63:0] d;
    wait_attn(1'b0);
    host.rd(7'h10, n, d);
    chk(d, exp);
  endtask

  task automatic touch(input logic [1:0] f);
    @(negedge clk);
    touch_valid = 1'b1;
    touch_fingers = f;
    @(negedge clk);
    touch_valid = 1'b0;
  endtask

  initial begin
    logic        ok;
    logic [63:0] d;
    rst_n = 1'b0;
    init_done = 1'b0;
    touch_valid = 1'b0;
    touch_fingers = 2'h0;
    tx1 = 12'hABC;
    ty1 = 12'h123;
    tx2 = 12'h456;
    ty2 = 12'h789;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk({attn_n, sda_oe_n, sens_x, sens_y, power_state, report_rate},
        {2'b11, 4'h5, 4'h4, 2'h2, 4'hA});
    repeat (20) @(negedge clk);
    host.rd(7'h10, 4, d);
    chk(d, 64'hFFFFFFFF);
    init_done = 1'b1;
    // Command queued while the hello still waits: hello must come first
    host.wr(7'h10, 32'h53500001, ok);
    chk(ok, 1'b1);
    fetch(4, 64'h55555555);
    fetch(4, 64'h52580A01);
    wait_attn(1'b1);
    host.wr(7'h10, 32'h54450001, ok);
    repeat (20) @(negedge clk);
    chk({sens_x, sens_y}, 8'h55);
    // Ordinary read commands and their responses
    for (int i = 0; i < 3; i++) begin
      host.wr(7'h10, cmd_rows[i], ok);
      fetch(4, exp_rows[i]);
    end
    host.wr(7'h10, 32'h60500001, ok);
    repeat (400) @(negedge clk);
    chk(attn_n, 1'b1);
    host.wr(7'h11, 32'h53500001, ok);
    chk(ok, 1'b0);
    repeat (400) @(negedge clk);
    chk(attn_n, 1'b1);
    touch(2'h2);
    fetch(8, 64'h5AA1BC2347568905);
    touch(2'h0);
    fetch(8, 64'h5AA1BC2347568905);
    fetch(8, 64'h5A00000000000001);
    wait_attn(1'b1);
    // Power write: state 01 from byte two, rate 5 from byte three
    host.wr(7'h10, 32'h54540501, ok);
    repeat (20) @(negedge clk);
    chk({power_state, report_rate}, {2'h1, 4'h5});
    test_done();
  end
endmodule // tb

// ===== sim/tp_host_model.sv
// Host bus master model for the touchpad link: bit-banged SCL and SDA.
// Assumes the bench resolves SDA with a pull-up from all open drains.
`timescale 1ns/1ps

module tp_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Quarter bit time; 2.5 us per bit keeps the bus at 400 kHz
  localparam time QTR = 625ns;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Data changes only while SCL is low; the host makes every pulse
  task automatic bit_out(input logic b);
    sda_low = ~b;
    #QTR scl = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
  endtask

  // Released line reads the pull-up unless the device pulls low
  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic start();
    #(2*QTR) sda_low = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #(2*QTR);
  endtask

  // Byte out MSB first, then the ninth clock samples the acknowledge
  task automatic send_byte(input touchpad_pkg::byte_t d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask

  // Write transfer: address with direction zero, then four bytes
  task automatic wr(input logic [6:0] a, input logic [31:0] pkt,
                    output logic ok);
    logic ack;
    start();
    send_byte({a, 1'b0}, ack);
    ok = ack;
    for (int i = 0; i < 4 && ack; i++) begin
      send_byte(pkt[31-8*i -: 8], ack);
      ok = ok & ack;
    end
    stop();
  endtask

  // Read transfer of n bytes; the last one is refused to end it
  task automatic rd(input logic [6:0] a, input int n,
                    output logic [63:0] d);
    logic ack;
    logic b;
    d = '0;
    start();
    send_byte({a, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 8; k++) begin
        bit_in(b);
        d = {d[62:0], b};
      end
      bit_out(i == n - 1);
    end
    stop();
  endtask
endmodule // tp_host_model
